// [imdp_pkg.sv]
// shared constants and types of the integer multiply/divide datapath
package imdp_pkg;

  localparam int XLEN      = 32;
  localparam int NREG      = 32;
  localparam int IDXW      = 5;
  localparam int NSETS     = 2;
  localparam int CNTW      = 6;

  // early-in skip counts by dividend width
  localparam logic [5:0] SKIP_W8  = 6'd23;
  localparam logic [5:0] SKIP_W16 = 6'd15;
  localparam logic [5:0] SKIP_W24 = 6'd7;
  localparam logic [5:0] SKIP_W32 = 6'd0;

  // busy cycles of the divider; the result lands one cycle later
  localparam logic [5:0] QREP_W8  = 6'd11;
  localparam logic [5:0] QREP_W16 = 6'd18;
  localparam logic [5:0] QREP_W24 = 6'd25;
  localparam logic [5:0] QREP_W32 = 6'd32;

  // value of register index zero and reset value of data registers
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    OP_NOP         = 5'h00,
    OP_AND         = 5'h01,
    OP_OR          = 5'h02,
    OP_XOR         = 5'h03,
    OP_NOR         = 5'h04,
    OP_ADD         = 5'h05,
    OP_SUB         = 5'h06,
    OP_SHL         = 5'h07,
    OP_SHR         = 5'h08,
    OP_SHRA        = 5'h09,
    OP_LEAD_ZEROS  = 5'h0a,
    OP_LEAD_ONES   = 5'h0b,
    OP_MOVE_UPPER  = 5'h0c,
    OP_MOVE_BOTTOM = 5'h0d,
    OP_WPROD       = 5'h0e,
    OP_WPRODU      = 5'h0f,
    OP_PACC        = 5'h10,
    OP_PACCU       = 5'h11,
    OP_PDED        = 5'h12,
    OP_PDEDU       = 5'h13,
    OP_GPRPROD     = 5'h14,
    OP_QUOT        = 5'h15,
    OP_QUOTU       = 5'h16
  } imdp_op_e;

  typedef enum logic [2:0] {
    DV_IDLE = 3'b001,
    DV_PREP = 3'b010,
    DV_ITER = 3'b100
  } imdp_dv_state_e;

endpackage : imdp_pkg

// [imdp_div_if.sv]
// link between the datapath and its iterative divider
interface imdp_div_if;
  logic        start;
  logic        is_signed;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        busy;
  logic        last;
  logic [31:0] quotient;
  logic [31:0] remainder;

  modport ctrl (output start, is_signed, dividend, divisor,
                input busy, last, quotient, remainder);
  modport unit (input start, is_signed, dividend, divisor,
                output busy, last, quotient, remainder);
endinterface : imdp_div_if

// [imdp_divider.sv]
// one-bit-per-clock restoring divider with early-in skip
module imdp_divider
  import imdp_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // datapath side
  imdp_div_if.unit  dv
);

  imdp_dv_state_e state_q, state_d;
  logic [5:0]     cnt_q, cnt_d;
  logic [5:0]     iter_q, iter_d;
  logic [32:0]    rem_q, rem_d;
  logic [31:0]    quo_q, quo_d;
  logic [31:0]    dsr_q, dsr_d;
  logic           qneg_q, qneg_d;
  logic           rneg_q, rneg_d;
  logic [31:0]    mag;
  logic [5:0]     skip;
  logic [5:0]     rep;
  logic [32:0]    trial;
  logic           sx;
  logic [31:0]    fin_quo;
  logic [31:0]    fin_rem;

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    iter_d  = iter_q;
    rem_d   = rem_q;
    quo_d   = quo_q;
    dsr_d   = dsr_q;
    qneg_d  = qneg_q;
    rneg_d  = rneg_q;
    sx      = dv.is_signed & dv.dividend[31];
    mag     = sx ? 32'(-dv.dividend) : dv.dividend;
    if (dv.dividend[31:7] == {25{sx}})
    begin
      skip = SKIP_W8;
      rep  = QREP_W8;
    end
    else if (dv.dividend[31:15] == {17{sx}})
    begin
      skip = SKIP_W16;
      rep  = QREP_W16;
    end
    else if (dv.dividend[31:23] == {9{sx}})
    begin
      skip = SKIP_W24;
      rep  = QREP_W24;
    end
    else
    begin
      skip = SKIP_W32;
      rep  = QREP_W32;
    end
    case (state_q)
      DV_IDLE:
      begin
        if (dv.start)
        begin
          // skipped iterations shift in at once
          quo_d   = mag << skip;
          rem_d   = 33'h0_0000_0000;
          iter_d  = 6'(XLEN) - skip;
          cnt_d   = rep;
          dsr_d   = (dv.is_signed & dv.divisor[31]) ? 32'(-dv.divisor)
                                                    : dv.divisor;
          qneg_d  = sx ^ (dv.is_signed & dv.divisor[31]);
          rneg_d  = sx;
          state_d = (rep > iter_d) ? DV_PREP : DV_ITER;
        end
      end
      DV_PREP:
      begin
        // setup cycles pad the shorter sizes to their fixed timing
        cnt_d = cnt_q - 6'd1;
        if (cnt_d == iter_q)
          state_d = DV_ITER;
      end
      DV_ITER:
      begin
        cnt_d  = cnt_q - 6'd1;
        iter_d = iter_q - 6'd1;
        if (!trial[32])
        begin
          rem_d = trial;
          quo_d = {quo_q[30:0], 1'b1};
        end
        else
        begin
          // a restored remainder is below the divisor, so bit 31 is clear
          rem_d = {1'b0, rem_q[30:0], quo_q[31]};
          quo_d = {quo_q[30:0], 1'b0};
        end
        if (cnt_q == 6'd1)
          state_d = DV_IDLE;
      end
      default:
        state_d = DV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= DV_IDLE;
      cnt_q   <= 6'd0;
      iter_q  <= 6'd0;
      rem_q   <= 33'h0_0000_0000;
      quo_q   <= WORD_RST;
      dsr_q   <= WORD_RST;
      qneg_q  <= 1'b0;
      rneg_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      iter_q  <= iter_d;
      rem_q   <= rem_d;
      quo_q   <= quo_d;
      dsr_q   <= dsr_d;
      qneg_q  <= qneg_d;
      rneg_q  <= rneg_d;
    end
  end

  assign dv.busy      = (state_q != DV_IDLE);
  assign dv.last      = (state_q == DV_ITER) && (cnt_q == 6'd1);
  // trial step from registers only, so start has no path back to the result
  assign trial        = {rem_q[31:0], quo_q[31]} - {1'b0, dsr_q};
  // final values are read by the datapath on the last busy cycle
  assign fin_quo      = {quo_q[30:0], !trial[32]};
  assign fin_rem      = trial[32] ? {rem_q[30:0], quo_q[31]} : trial[31:0];
  assign dv.quotient  = qneg_q ? 32'(-fin_quo) : fin_quo;
  assign dv.remainder = rneg_q ? 32'(-fin_rem) : fin_rem;

endmodule // imdp_divider

// [imdp_core.sv]
// integer execution datapath: register file, alu and multiply/divide
// Functional notes
// - multiply/divide work runs on independent of integer pipe stalls
// - built from 32x16 multiplier, upper/bottom words, divide machine
// - pass count chosen only from right operand size, detected here
// - 16-bit right operand multiplies issue every cycle, 32-bit every other
// - back-to-back 32x32 multiplies are held off by interlock
// - division iterates one quotient bit per clock
// - divider skips 23, 15 or 7 iterations by dividend width
// - any multiply/divide op waits while a division is active
// - widening/accumulate products: latency 1/2, repeat 1/2 cycles
// - register-target product: latency 2/3, repeat 1/2 cycles
// - division latency/repeat 12/12, 19/19, 26/26, 33/33 by dividend
// - results land in upper/bottom words; moves copy them to registers
// - register-target product writes low bits straight to register file
// - accumulate adds product into upper:bottom pair
// - deduct subtracts product from upper:bottom pair
// - logic, shift, add, subtract complete in one cycle
// - 32x32-bit register file, two reads, one write, bypassed
// - one shadow copy of the register file, selectable
// - leading zero/one counter for 32-bit operand
module imdp_core
  import imdp_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // issue from the integer pipe
  input  wire logic             iss_valid,
  input  wire imdp_pkg::imdp_op_e iss_op,
  input  wire logic [4:0]       iss_src_a,
  input  wire logic [4:0]       iss_src_b,
  input  wire logic [4:0]       iss_dst,
  input  wire logic [4:0]       iss_shamt,
  input  wire logic             shadow_sel,
  // issue permission
  output logic                  wr_free_q,
  output logic                  mdu_free_q,
  output logic                  div_busy_q,
  // register write result
  output logic                  res_valid_q,
  output logic [4:0]            res_dst_q,
  output logic [31:0]           res_data_q,
  // operands and accumulator
  output logic [31:0]           rd_a_q,
  output logic [31:0]           rd_b_q,
  output logic [31:0]           upper_acc_word_q,
  output logic [31:0]           bottom_acc_word_q
);

  imdp_div_if dvi ();

  logic [31:0] rf_q [NSETS][NREG];
  logic        m2_q, m2_d;
  logic [2:0]  m2_kind_q, m2_kind_d;
  logic [63:0] part_q, part_d;
  logic [31:0] m2_a_q, m2_a_d;
  logic [15:0] m2_b_q, m2_b_d;
  logic        m2_sg_q, m2_sg_d;
  logic [4:0]  m2_dst_q, m2_dst_d;
  logic        m2_set_q, m2_set_d;
  logic        wb_q, wb_d;
  logic [4:0]  wb_dst_q, wb_dst_d;
  logic [31:0] wb_data_q, wb_data_d;
  logic        wb_set_q, wb_set_d;
  logic [31:0] hi_d, lo_d;
  logic        wr_free_d, mdu_free_d, div_busy_d;
  logic        res_valid_d;
  logic [4:0]  res_dst_d;
  logic [31:0] res_data_d;
  logic        res_set_d;
  logic [31:0] opa, opb, alu;
  logic        is_mdu, is_wr, take, sg, fit16;
  logic [2:0]  kind;
  logic [63:0] prod, acc;

  // register read with bypass from the write landing this edge
  function automatic logic [31:0] rf_read(input logic set,
                                          input logic [4:0] idx);
    logic [31:0] v;
    v = rf_q[set][idx];
    if (wb_q && wb_set_q == set && wb_dst_q == idx)
      v = wb_data_q;
    if (idx == 5'd0)
      v = WORD_RST;
    return v;
  endfunction

  // one 32x16 pass; the slice carries its own sign bit
  function automatic logic [63:0] booth_pass(input logic [31:0] a,
                                             input logic [16:0] b,
                                             input logic        s);
    logic signed [32:0] ax;
    logic signed [49:0] p;
    ax = {s & a[31], a};
    p  = 50'(ax) * 50'($signed(b));
    return {{14{p[49]}}, p};
  endfunction

  function automatic logic [31:0] lead_count(input logic [31:0] x,
                                             input logic        ones);
    logic [31:0] n;
    logic        run;
    n   = WORD_RST;
    run = 1'b1;
    for (int i = 31; i >= 0; i--)
    begin
      run = run & (x[i] == ones);
      n   = n + {31'h0, run};
    end
    return n;
  endfunction

  // kind codes: 0 widen, 1 accumulate, 2 deduct, 3 register target
  function automatic logic [63:0] combine(input logic [2:0]  k,
                                          input logic [63:0] p,
                                          input logic [31:0] h,
                                          input logic [31:0] l);
    logic [63:0] r;
    case (k)
      3'd1:    r = {h, l} + p;
      3'd2:    r = {h, l} - p;
      default: r = p;
    endcase
    return r;
  endfunction

  imdp_divider u_div (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .dv      (dvi.unit)
  );

  always_comb
  begin
    opa  = rf_read(shadow_sel, iss_src_a);
    opb  = rf_read(shadow_sel, iss_src_b);
    sg   = 1'b1;
    kind = 3'd0;
    case (iss_op)
      OP_WPRODU, OP_PACCU, OP_PDEDU, OP_QUOTU: sg = 1'b0;
      default: sg = 1'b1;
    endcase
    case (iss_op)
      OP_PACC, OP_PACCU: kind = 3'd1;
      OP_PDED, OP_PDEDU: kind = 3'd2;
      OP_GPRPROD:        kind = 3'd3;
      default:           kind = 3'd0;
    endcase
    is_mdu = (iss_op >= OP_MOVE_UPPER);
    is_wr  = (iss_op != OP_NOP) && (iss_op <= OP_MOVE_BOTTOM);
    // issue waits on the free flags
    take   = iss_valid && (!is_mdu || mdu_free_q) && (!is_wr || wr_free_q);
    // size is decided from the right operand only
    fit16  = sg ? (opb[31:15] == {17{opb[31]}}) : (opb[31:16] == 16'h0);
    case (iss_op)
      OP_AND:         alu = opa & opb;
      OP_OR:          alu = opa | opb;
      OP_XOR:         alu = opa ^ opb;
      OP_NOR:         alu = ~(opa | opb);
      OP_ADD:         alu = opa + opb;
      OP_SUB:         alu = opa - opb;
      OP_SHL:         alu = opb << iss_shamt;
      OP_SHR:         alu = opb >> iss_shamt;
      OP_SHRA:        alu = 32'($signed(opb) >>> iss_shamt);
      OP_LEAD_ZEROS:  alu = lead_count(opa, 1'b0);
      OP_LEAD_ONES:   alu = lead_count(opa, 1'b1);
      // copy out of the accumulator pair
      OP_MOVE_UPPER:  alu = upper_acc_word_q;
      OP_MOVE_BOTTOM: alu = bottom_acc_word_q;
      default:        alu = WORD_RST;
    endcase

    hi_d      = upper_acc_word_q;
    lo_d      = bottom_acc_word_q;
    m2_d      = 1'b0;
    m2_kind_d = m2_kind_q;
    part_d    = part_q;
    m2_a_d    = m2_a_q;
    m2_b_d    = m2_b_q;
    m2_sg_d   = m2_sg_q;
    m2_dst_d  = m2_dst_q;
    m2_set_d  = m2_set_q;
    wb_d      = 1'b0;
    wb_dst_d  = wb_dst_q;
    wb_data_d = wb_data_q;
    wb_set_d  = wb_set_q;
    prod      = 64'h0;
    acc       = 64'h0;

    // the second pass and the divider never look at the pipe
    if (m2_q)
    begin
      // second pass on the upper right-operand slice
      prod = part_q + (booth_pass(m2_a_q, {m2_sg_q & m2_b_q[15], m2_b_q},
                                  m2_sg_q) << 16);
      acc  = combine(m2_kind_q, prod, upper_acc_word_q, bottom_acc_word_q);
      if (m2_kind_q == 3'd3)
      begin
        wb_d      = 1'b1;
        wb_dst_d  = m2_dst_q;
        wb_data_d = acc[31:0];
        wb_set_d  = m2_set_q;
      end
      else
      begin
        // 32-bit operand result after two cycles
        hi_d = acc[63:32];
        lo_d = acc[31:0];
      end
    end

    dvi.start     = 1'b0;
    dvi.is_signed = sg;
    dvi.dividend  = opa;
    dvi.divisor   = opb;

    if (take && iss_op >= OP_WPROD && iss_op <= OP_GPRPROD)
    begin
      if (fit16)
      begin
        prod = booth_pass(opa, sg ? opb[16:0] : {1'b0, opb[15:0]}, sg);
        acc  = combine(kind, prod, upper_acc_word_q, bottom_acc_word_q);
        if (kind == 3'd3)
        begin
          // low product bits go to the register file
          wb_d      = 1'b1;
          wb_dst_d  = iss_dst;
          wb_data_d = acc[31:0];
          wb_set_d  = shadow_sel;
        end
        else
        begin
          hi_d = acc[63:32];
          lo_d = acc[31:0];
        end
      end
      else
      begin
        // full-width operand needs a second pass
        m2_d      = 1'b1;
        m2_kind_d = kind;
        part_d    = booth_pass(opa, {1'b0, opb[15:0]}, sg);
        m2_a_d    = opa;
        m2_b_d    = opb[31:16];
        m2_sg_d   = sg;
        m2_dst_d  = iss_dst;
        m2_set_d  = shadow_sel;
      end
    end

    if (take && (iss_op == OP_QUOT || iss_op == OP_QUOTU))
      dvi.start = 1'b1;
    if (dvi.last)
    begin
      hi_d = dvi.remainder;
      lo_d = dvi.quotient;
    end

    div_busy_d = dvi.start || (dvi.busy && !dvi.last);
    // a follow-on multiply waits out the second pass
    mdu_free_d = !m2_d && !div_busy_d;
    // the single write port goes to a pending product first
    wr_free_d  = !wb_d;

    res_valid_d = 1'b0;
    res_dst_d   = res_dst_q;
    res_data_d  = res_data_q;
    res_set_d   = 1'b0;
    if (wb_q)
    begin
      res_valid_d = 1'b1;
      res_dst_d   = wb_dst_q;
      res_data_d  = wb_data_q;
      res_set_d   = wb_set_q;
    end
    else if (take && is_wr)
    begin
      res_valid_d = 1'b1;
      res_dst_d   = iss_dst;
      res_data_d  = alu;
      res_set_d   = shadow_sel;
    end
  end

  // one write port, index zero never written
  always_ff @(posedge sys_clk)
  begin
    if (res_valid_d && res_dst_d != 5'd0)
      rf_q[res_set_d][res_dst_d] <= res_data_d;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      upper_acc_word_q  <= WORD_RST;
      bottom_acc_word_q <= WORD_RST;
      m2_q              <= 1'b0;
      m2_kind_q         <= 3'd0;
      part_q            <= 64'h0;
      m2_a_q            <= WORD_RST;
      m2_b_q            <= 16'h0;
      m2_sg_q           <= 1'b0;
      m2_dst_q          <= 5'd0;
      m2_set_q          <= 1'b0;
      wb_q              <= 1'b0;
      wb_dst_q          <= 5'd0;
      wb_data_q         <= WORD_RST;
      wb_set_q          <= 1'b0;
      wr_free_q         <= 1'b1;
      mdu_free_q        <= 1'b1;
      div_busy_q        <= 1'b0;
      res_valid_q       <= 1'b0;
      res_dst_q         <= 5'd0;
      res_data_q        <= WORD_RST;
      rd_a_q            <= WORD_RST;
      rd_b_q            <= WORD_RST;
    end
    else
    begin
      upper_acc_word_q  <= hi_d;
      bottom_acc_word_q <= lo_d;
      m2_q              <= m2_d;
      m2_kind_q         <= m2_kind_d;
      part_q            <= part_d;
      m2_a_q            <= m2_a_d;
      m2_b_q            <= m2_b_d;
      m2_sg_q           <= m2_sg_d;
      m2_dst_q          <= m2_dst_d;
      m2_set_q          <= m2_set_d;
      wb_q              <= wb_d;
      wb_dst_q          <= wb_dst_d;
      wb_data_q         <= wb_data_d;
      wb_set_q          <= wb_set_d;
      wr_free_q         <= wr_free_d;
      mdu_free_q        <= mdu_free_d;
      div_busy_q        <= div_busy_d;
      res_valid_q       <= res_valid_d;
      res_dst_q         <= res_dst_d;
      res_data_q        <= res_data_d;
      rd_a_q            <= opa;
      rd_b_q            <= opb;
    end
  end

endmodule // imdp_core

// [imdp_core_asserts.sv]
// port assertions of the integer multiply/divide datapath
module imdp_core_asserts
  import imdp_pkg::*;
(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  // issue
  input wire logic               iss_valid,
  input wire imdp_pkg::imdp_op_e iss_op,
  input wire logic [4:0]         iss_dst,
  // flags and results
  input wire logic               wr_free_q,
  input wire logic               mdu_free_q,
  input wire logic               div_busy_q,
  input wire logic               res_valid_q,
  input wire logic [4:0]         res_dst_q,
  input wire logic [31:0]        upper_acc_word_q,
  input wire logic [31:0]        bottom_acc_word_q
);
  logic mdu_take;
  logic wr_take;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // a refused request must not count as taken
  assign mdu_take = iss_valid && mdu_free_q && iss_op >= OP_WPROD;
  // r0 writes are discarded, so they are left out
  assign wr_take = iss_valid && wr_free_q && iss_dst != 5'h00 &&
                   iss_op inside {[OP_AND:OP_MOVE_BOTTOM]} &&
                   (iss_op < OP_MOVE_UPPER || mdu_free_q);

  sequence s_div_go;
    mdu_take && iss_op inside {OP_QUOT, OP_QUOTU};
  endsequence
  sequence s_busy_min;
    div_busy_q [*8] ##1 div_busy_q [*3];
  endsequence

  a_div_busy_min:
    assert property (s_div_go |=> s_busy_min)
    else $error("divider busy for fewer than eleven cycles");
  a_div_busy_max:
    assert property ($rose(div_busy_q) |-> ##[11:32] !div_busy_q)
    else $error("divider busy for more than thirty-two cycles");
  a_div_hold_mdu:
    assert property (div_busy_q |-> !mdu_free_q)
    else $error("multiply side free while divider busy");
  a_div_acc_still:
    assert property (div_busy_q |->
      $stable(upper_acc_word_q) && $stable(bottom_acc_word_q))
    else $error("accumulator changed during division");
  a_wide_one_gap:
    assert property (!mdu_free_q && !div_busy_q |=> mdu_free_q)
    else $error("multiply side held off for more than one cycle");
  a_mdu_stall_cause:
    assert property ($fell(mdu_free_q) |-> $past(mdu_take))
    else $error("multiply side held off with no op taken");
  a_alu_one_cycle:
    assert property (wr_take |=> res_valid_q && res_dst_q == $past(iss_dst))
    else $error("register write missing one cycle after issue");
  a_gpr_write:
    assert property ($fell(wr_free_q) |=> res_valid_q)
    else $error("register-target product write missing");
endmodule // imdp_core_asserts

bind imdp_core imdp_core_asserts u_chk (
  .sys_clk, .sys_rst, .iss_valid, .iss_op, .iss_dst, .wr_free_q,
  .mdu_free_q, .div_busy_q, .res_valid_q, .res_dst_q,
  .upper_acc_word_q, .bottom_acc_word_q
);

// [imdp_pipe_model.sv]
// integer pipe model: presents one op and holds it until taken
module imdp_pipe_model
  import imdp_pkg::*;
(
  // clock
  input  wire logic          sys_clk,
  // issue permission
  input  wire logic          wr_free_q,
  input  wire logic          mdu_free_q,
  // issue
  output logic               iss_valid = 1'b0,
  output imdp_pkg::imdp_op_e iss_op = OP_NOP,
  output logic [4:0]         iss_src_a = 5'h00,
  output logic [4:0]         iss_src_b = 5'h00,
  output logic [4:0]         iss_dst = 5'h00,
  output logic [4:0]         iss_shamt = 5'h00,
  output logic               shadow_sel = 1'b0
);
  function automatic logic ok(input imdp_op_e op);
    return (op > OP_MOVE_BOTTOM || wr_free_q === 1'b1) &&
           (op < OP_MOVE_UPPER || mdu_free_q === 1'b1);
  endfunction

  // returns in the cycle whose closing edge takes the op
  task automatic issue(input imdp_op_e op, input logic [4:0] a, b, d, sh,
                       input logic s, output int stalls);
    @(posedge sys_clk);
    iss_valid  <= 1'b1;
    iss_op     <= op;
    iss_src_a  <= a;
    iss_src_b  <= b;
    iss_dst    <= d;
    iss_shamt  <= sh;
    shadow_sel <= s;
    stalls = 0;
    @(negedge sys_clk);
    while (!ok(op) && stalls < 100)
    begin
      stalls++;
      @(negedge sys_clk);
    end
  endtask

  // released fields stop showing the last request
  task automatic idle();
    @(posedge sys_clk);
    iss_valid <= 1'b0;
    iss_op    <= OP_NOP;
    iss_src_a <= ~iss_src_a;
    iss_src_b <= ~iss_src_b;
    iss_dst   <= ~iss_dst;
    iss_shamt <= ~iss_shamt;
  endtask
endmodule // imdp_pipe_model

// [tb.sv]
// self-checking bench for the integer multiply/divide datapath
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import imdp_pkg::*;

  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        iss_valid, shadow_sel, wr_free_q, mdu_free_q;
  logic        div_busy_q, res_valid_q;
  imdp_op_e    iss_op;
  logic [4:0]  iss_src_a, iss_src_b, iss_dst, iss_shamt, res_dst_q;
  logic [31:0] res_data_q, rd_a_q, rd_b_q;
  logic [31:0] upper_acc_word_q, bottom_acc_word_q;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          st;
  logic [31:0] v [0:63];
  logic [63:0] acc;

  always #2 sys_clk = ~sys_clk;

  imdp_core dut (.sys_clk, .sys_rst, .iss_valid, .iss_op, .iss_src_a,
    .iss_src_b, .iss_dst, .iss_shamt, .shadow_sel, .wr_free_q,
    .mdu_free_q, .div_busy_q, .res_valid_q, .res_dst_q, .res_data_q,
    .rd_a_q, .rd_b_q, .upper_acc_word_q, .bottom_acc_word_q);

  imdp_pipe_model pipe (.sys_clk, .wr_free_q, .mdu_free_q, .iss_valid,
    .iss_op, .iss_src_a, .iss_src_b, .iss_dst, .iss_shamt, .shadow_sel);

  task automatic check(input logic [71:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lead(logic [31:0] x, logic o);
    int n = 0;
    while (n < 32 && x[31-n] == o)
      n++;
    return n;
  endfunction

  function automatic logic [31:0] alu(imdp_op_e op, logic [31:0] a, b,
                                      logic [4:0] sh);
    case (op)
      OP_AND:        return a & b;
      OP_OR:         return a | b;
      OP_XOR:        return a ^ b;
      OP_NOR:        return ~(a | b);
      OP_ADD:        return a + b;
      OP_SUB:        return a - b;
      OP_SHL:        return b << sh;
      OP_SHR:        return b >> sh;
      OP_SHRA:       return $signed(b) >>> sh;
      OP_LEAD_ZEROS: return lead(a, 1'b0);
      OP_LEAD_ONES:  return lead(a, 1'b1);
      OP_MOVE_UPPER: return acc[63:32];
      default:       return acc[31:0];
    endcase
  endfunction

  // one register-writing op, result one cycle after it is taken
  task automatic wr(imdp_op_e op, int a, b, d, sh, s, int es = 0);
    logic [31:0] e;
    logic [63:0] ops;
    ops = {v[s * 32 + a], v[s * 32 + b]};
    e = alu(op, ops[63:32], ops[31:0], sh[4:0]);
    pipe.issue(op, a[4:0], b[4:0], d[4:0], sh[4:0], s[0], st);
    pipe.idle();
    @(negedge sys_clk);
    check(st, es);
    check({res_valid_q, res_dst_q, res_data_q}, {1'b1, d[4:0], e});
    check({rd_a_q, rd_b_q}, ops);
    v[s * 32 + d] = e;
  endtask

  task automatic mul(imdp_op_e op, int a, b, d, lat);
    logic        u;
    logic [63:0] x, y, p, old;
    u = op inside {OP_WPRODU, OP_PACCU, OP_PDEDU};
    x = {{32{v[a][31] & !u}}, v[a]};
    y = {{32{v[b][31] & !u}}, v[b]};
    p = x * y;
    old = acc;
    case (op)
      OP_WPROD, OP_WPRODU: acc = p;
      OP_PACC, OP_PACCU:   acc = old + p;
      OP_PDED, OP_PDEDU:   acc = old - p;
      default:             v[d] = p[31:0];
    endcase
    pipe.issue(op, a[4:0], b[4:0], d[4:0], 5'h00, 1'b0, st);
    pipe.idle();
    repeat (lat - 1) @(negedge sys_clk);
    if (lat > 1)
      check({upper_acc_word_q, bottom_acc_word_q, res_valid_q},
            {old, 1'b0});
    @(negedge sys_clk);
    check({upper_acc_word_q, bottom_acc_word_q}, acc);
    if (op == OP_GPRPROD)
      check({res_valid_q, res_dst_q, res_data_q},
            {1'b1, d[4:0], p[31:0]});
  endtask

  task automatic t_alu();
    int pr [3][2] = '{'{2, 3}, '{4, 1}, '{1, 3}};
    wr(OP_NOR, 0, 0, 1, 0, 0);
    wr(OP_SHR, 0, 1, 2, 17, 0);
    wr(OP_SHR, 0, 1, 3, 1, 0);
    wr(OP_SHR, 0, 1, 4, 30, 0);
    wr(OP_SHR, 0, 1, 5, 9, 0);
    wr(OP_SHR, 0, 1, 6, 25, 0);
    foreach (pr[k])
      for (int o = OP_AND; o <= OP_LEAD_ONES; o++)
        wr(imdp_op_e'(o), pr[k][0], pr[k][1], 7, o + 2, 0);
    // dependent op right behind its producer reads the register written at the edge that took it
    pipe.issue(OP_OR, 5'h01, 5'h00, 5'h08, 5'h00, 1'b0, st);
    v[8] = v[1];
    wr(OP_AND, 8, 2, 9, 0, 0);
    wr(OP_NOR, 0, 0, 13, 0, 1);
    wr(OP_SHR, 0, 1, 13, 17, 0);
    wr(OP_OR, 13, 0, 14, 0, 1);
    wr(OP_OR, 13, 0, 14, 0, 0);
  endtask

  task automatic t_mul();
    mul(OP_WPRODU, 1, 1, 0, 2);
    mul(OP_WPROD, 1, 1, 0, 1);
    mul(OP_PACC, 3, 2, 0, 1);
    mul(OP_PDED, 2, 3, 0, 2);
    mul(OP_PACCU, 1, 4, 0, 1);
    mul(OP_PDEDU, 4, 1, 0, 2);
    mul(OP_GPRPROD, 3, 2, 9, 2);
    mul(OP_GPRPROD, 2, 3, 9, 3);
    wr(OP_MOVE_UPPER, 0, 0, 10, 0, 0);
    wr(OP_MOVE_BOTTOM, 0, 0, 11, 0, 0);
  endtask

  task automatic t_rate();
    pipe.issue(OP_WPROD, 5'h02, 5'h02, 5'h00, 5'h00, 1'b0, st);
    pipe.issue(OP_WPROD, 5'h02, 5'h02, 5'h00, 5'h00, 1'b0, st);
    check(st, 0);
    pipe.issue(OP_WPROD, 5'h03, 5'h03, 5'h00, 5'h00, 1'b0, st);
    pipe.issue(OP_WPROD, 5'h03, 5'h03, 5'h00, 5'h00, 1'b0, st);
    check(st, 1);
    pipe.idle();
    repeat (2) @(negedge sys_clk);
    acc = {32'h0, v[3]} * {32'h0, v[3]};
    check({upper_acc_word_q, bottom_acc_word_q}, acc);
  endtask

  task automatic t_div();
    int          dd [6] = '{6, 2, 5, 3, 1, 1};
    int          lat [6] = '{12, 19, 26, 33, 12, 33};
    logic [31:0] q, r;
    imdp_op_e    op;
    for (int i = 0; i < 6; i++)
    begin
      op = OP_QUOT;
      q = $signed(v[dd[i]]) / $signed(v[4]);
      r = $signed(v[dd[i]]) % $signed(v[4]);
      if (i == 5)
      begin
        op = OP_QUOTU;
        q = v[1] / v[4];
        r = v[1] % v[4];
      end
      acc = {r, q};
      pipe.issue(op, dd[i][4:0], 5'h04, 5'h00, 5'h00, 1'b0, st);
      wr(OP_NOR, 0, 0, 10, 0, 0);
      check(div_busy_q, 1'b1);
      wr(OP_MOVE_BOTTOM, 0, 0, 11, 0, 0, lat[i] - 3);
      wr(OP_MOVE_UPPER, 0, 0, 12, 0, 0);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    v[0] = 32'h0000_0000;
    v[32] = 32'h0000_0000;
    acc = 64'h0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_alu();
    $display("test alu done");
    t_mul();
    $display("test mul done");
    t_rate();
    $display("test rate done");
    t_div();
    $display("test div done");
    finish_test();
  end

  // the tests need well under two thousand cycles
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule // tb
